// ===== core/ncb_bus_cycle.v
// single write or read cycle on the parallel flash pins
// assumes asynchronous flash timing met by whole reference clock cycles
`timescale 1ns/1ps
`include "ncb_consts.vh"

module ncb_bus_cycle #(
  parameter WE_CYC = (`NCB_T_WE_NS + `NCB_CLK_NS - 1) / `NCB_CLK_NS,
  parameter RD_CYC = (`NCB_T_RD_NS + `NCB_CLK_NS - 1) / `NCB_CLK_NS
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // request
  input  wire        go,
  input  wire        is_rd,
  input  wire [26:0] addr,
  input  wire [15:0] wdata,
  // answer
  output reg         busy,
  output reg         done,
  output reg  [15:0] rdata,
  // pins
  output reg  [26:0] a_out,
  output reg  [15:0] dq_out,
  output reg         dq_oe,
  input  wire [15:0] dq_in,
  output reg         ce_b,
  output reg         oe_b,
  output reg         we_b
);

  reg [3:0] cnt_r;
  reg       rd_r;

  // --------------------------------------------------------------------
  // strobe sequencer
  // --------------------------------------------------------------------
  // data is held one cycle past we rising edge for hold time
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      rdata  <= 16'h0000;
      a_out  <= 27'h000_0000;
      dq_out <= 16'h0000;
      dq_oe  <= 1'b0;
      ce_b   <= 1'b1;
      oe_b   <= 1'b1;
      we_b   <= 1'b1;
      cnt_r  <= 4'h0;
      rd_r   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (go) begin
          busy   <= 1'b1;
          rd_r   <= is_rd;
          a_out  <= addr;
          dq_out <= wdata;
          dq_oe  <= !is_rd;
          ce_b   <= 1'b0;
          oe_b   <= !is_rd;
          we_b   <= is_rd;
          cnt_r  <= is_rd ? RD_CYC[3:0] : WE_CYC[3:0];
        end
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (!ce_b) begin
        if (rd_r)
          rdata <= dq_in;
        ce_b <= 1'b1;
        oe_b <= 1'b1;
        we_b <= 1'b1;
      end else begin
        dq_oe <= 1'b0; // release after hold cycle
        busy  <= 1'b0;
        done  <= 1'b1;
      end
    end
  end

endmodule // ncb_bus_cycle

// ===== core/ncb_consts.vh
// constants for the nor flash crc and bypass command host controller
// assumes a x16 parallel nor flash with word addressing on its pins
`ifndef NCB_CONSTS_VH
`define NCB_CONSTS_VH

// unlock and command addresses (word addresses)
`define NCB_ADDR_UNLOCK1   27'h000_0555
`define NCB_ADDR_UNLOCK2   27'h000_02AA
`define NCB_ADDR_ZERO      27'h000_0000
`define NCB_ADDR_CRC0      27'h000_0001
`define NCB_ADDR_START_LO  27'h000_0005
`define NCB_ADDR_STOP_LO   27'h000_0008
`define NCB_ADDR_STOP_HI   27'h000_0009
`define NCB_ADDR_RSVD2     27'h000_000A

// command data codes
`define NCB_D_UNLOCK1      16'h00AA
`define NCB_D_UNLOCK2      16'h0055
`define NCB_D_EXTFN        16'h00EB
`define NCB_D_CRC_SUB      16'h0027
`define NCB_D_CNT_RANGE    16'h000A
`define NCB_D_OPT_RANGE    16'hFFFE
`define NCB_D_CNT_DIE      16'h0004
`define NCB_D_OPT_DIE      16'hFFFF
`define NCB_D_CONFIRM      16'h0029
`define NCB_D_BYP_ENTER    16'h0020
`define NCB_D_BYP_EXIT1    16'h0090
`define NCB_D_BYP_EXIT2    16'h0000
`define NCB_D_READ_RESET   16'h00F0
`define NCB_D_RSVD         16'h0000

// status polling bit positions
`define NCB_BIT_DONE       7
`define NCB_BIT_TOGGLE     6
`define NCB_BIT_CHKERR     5

// bus timing in ns at the 20 mhz reference clock
`define NCB_CLK_NS         50
`define NCB_T_WE_NS        100
`define NCB_T_RD_NS        150

// command kinds
`define NCB_CMD_CRC_DIE    2'h0
`define NCB_CMD_CRC_RANGE  2'h1
`define NCB_CMD_BYP_ENTER  2'h2
`define NCB_CMD_BYP_EXIT   2'h3

// writes per crc sequence, confirm included
`define NCB_N_WR_DIE       5'h0B
`define NCB_N_WR_RANGE     5'h11

`endif

// ===== core/ncb_host.v
// host controller issuing crc and unlock bypass sequences to a nor flash
// assumes one flash die per chip select and synchronous pin inputs
//
// Contract
// - write aa, 55, eb, 27 sequence
// - range count 0a, option fffe, ten words
// - whole die count 04, option ffff
// - expected crc words at offsets 1..4
// - start byte address packed at 5, 6
// - stop byte address packed at 8, 9
// - write confirm 29, then poll until ready
// - host keeps range inside one die; the code does not check this, CMD_START and CMD_STOP pass as given
// - bypass entry is three writes
// - host uses commands, not pin voltage
// - bypass exit is 90 then 00
`timescale 1ns/1ps
`include "ncb_consts.vh"

module ncb_host #(
  parameter DIES    = 2,
  parameter MAX_POLL = 16'hFFFF
) (
  // clock and reset
  input  wire        REF_CLK,
  input  wire        RST_B,
  // command request
  input  wire        CMD_VALID,
  input  wire [1:0]  CMD_KIND,
  input  wire        CMD_DIE,
  input  wire [63:0] CMD_CRC,
  input  wire [30:0] CMD_START,
  input  wire [30:0] CMD_STOP,
  output reg         CMD_READY,
  // command answer
  output reg         DONE,
  output reg         CHECK_FAIL,
  output reg         TIMEOUT,
  output reg         RANGE_SKIP,
  output reg         BYPASS_ON,
  // flash pins
  output reg  [26:0] A_OUT,
  output reg  [15:0] DQ_OUT,
  output reg         DQ_OE,
  input  wire [15:0] DQ_IN,
  output reg  [1:0]  CE_B,
  output reg         OE_B,
  output reg         WE_B,
  output reg         ACCEL_HV_REQ
);

  localparam S_IDLE = 3'h0;
  localparam S_WR   = 3'h1;
  localparam S_WAIT = 3'h2;
  localparam S_POLL = 3'h3;
  localparam S_PWT  = 3'h4;
  localparam S_CLR  = 3'h5;
  localparam S_CWT  = 3'h6;
  localparam S_END  = 3'h7;

  reg  [2:0]  state_r;
  reg  [4:0]  step_r;
  reg  [1:0]  kind_r;
  reg         die_r;
  reg  [63:0] crc_r;
  reg  [30:0] start_r;
  reg  [30:0] stop_r;
  reg  [15:0] poll_cnt_r;
  reg  [15:0] last_r;
  reg         have_last_r;
  reg  [DIES-1:0] byp_r;
  reg         go_r;
  reg         rd_r;
  reg  [26:0] addr_r;
  reg  [15:0] wdata_r;
  reg  [4:0]  nsteps;
  reg  [1:0]  word_sel;
  reg  [26:0] step_addr;
  reg  [15:0] step_data;

  wire        cyc_busy;
  wire        cyc_done;
  wire [15:0] cyc_rdata;
  wire [26:0] cyc_a;
  wire [15:0] cyc_dq;
  wire        cyc_oe;
  wire        cyc_ce_b;
  wire        cyc_oe_b;
  wire        cyc_we_b;

  // --------------------------------------------------------------------
  // sequence table
  // --------------------------------------------------------------------
  // low address half packs into data bits 15..1, bit 0 stays zero
  function [15:0] pack_lo;
    input [30:0] a;
    begin
      pack_lo = {a[14:0], 1'b0};
    end
  endfunction

  // each command kind expands into a fixed list of writes
  always @* begin
    step_addr = `NCB_ADDR_ZERO;
    step_data = `NCB_D_RSVD;
    nsteps    = 5'h00;
    // kept two bits wide so the wrap at step 8 cannot grow into a huge index
    word_sel  = step_r[1:0] - 2'h2;
    case (kind_r)
      `NCB_CMD_CRC_DIE, `NCB_CMD_CRC_RANGE: begin
        nsteps = (kind_r == `NCB_CMD_CRC_RANGE) ?
                 `NCB_N_WR_RANGE : `NCB_N_WR_DIE;
        case (step_r)
          5'h00: begin
            step_addr = `NCB_ADDR_UNLOCK1;
            step_data = `NCB_D_UNLOCK1;
          end
          5'h01: begin
            step_addr = `NCB_ADDR_UNLOCK2;
            step_data = `NCB_D_UNLOCK2;
          end
          5'h02: step_data = `NCB_D_EXTFN;
          5'h03: step_data = `NCB_D_CRC_SUB;
          5'h04: step_data = (kind_r == `NCB_CMD_CRC_RANGE) ?
                             `NCB_D_CNT_RANGE : `NCB_D_CNT_DIE;
          5'h05: step_data = (kind_r == `NCB_CMD_CRC_RANGE) ?
                             `NCB_D_OPT_RANGE : `NCB_D_OPT_DIE;
          5'h06, 5'h07, 5'h08, 5'h09: begin
            // first word at offset 1 carries the low sixteen bits
            step_addr = `NCB_ADDR_CRC0 + {25'h000_0000, word_sel};
            step_data = crc_r[{word_sel, 4'h0} +: 16];
          end
          default: begin
            if (kind_r == `NCB_CMD_CRC_DIE || step_r == `NCB_N_WR_RANGE - 5'h01) begin
              step_data = `NCB_D_CONFIRM;
            end else begin
              // offsets 5 to A follow in address order, one word per step
              step_addr = `NCB_ADDR_START_LO + {22'h00_0000, step_r - 5'h0A};
              case (step_r)
                5'h0A: step_data = pack_lo(start_r);
                5'h0B: step_data = start_r[30:15];
                5'h0D: step_data = pack_lo(stop_r);
                5'h0E: step_data = stop_r[30:15];
                default: step_data = `NCB_D_RSVD;
              endcase
            end
          end
        endcase
      end
      `NCB_CMD_BYP_ENTER: begin
        nsteps = 5'h03;
        case (step_r)
          5'h00: begin
            step_addr = `NCB_ADDR_UNLOCK1;
            step_data = `NCB_D_UNLOCK1;
          end
          5'h01: begin
            step_addr = `NCB_ADDR_UNLOCK2;
            step_data = `NCB_D_UNLOCK2;
          end
          default: begin
            step_addr = `NCB_ADDR_UNLOCK1;
            step_data = `NCB_D_BYP_ENTER;
          end
        endcase
      end
      default: begin
        nsteps    = 5'h02;
        step_data = (step_r == 5'h00) ? `NCB_D_BYP_EXIT1 : `NCB_D_BYP_EXIT2;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  // poll until the toggle bit stops toggling; the wait is bounded so a
  // dead device cannot hang the host forever
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r     <= S_IDLE;
      step_r      <= 5'h00;
      kind_r      <= `NCB_CMD_CRC_DIE;
      die_r       <= 1'b0;
      crc_r       <= 64'h0000_0000_0000_0000;
      start_r     <= 31'h0000_0000;
      stop_r      <= 31'h0000_0000;
      poll_cnt_r  <= 16'h0000;
      last_r      <= 16'h0000;
      have_last_r <= 1'b0;
      byp_r       <= {DIES{1'b0}};
      go_r        <= 1'b0;
      rd_r        <= 1'b0;
      addr_r      <= 27'h000_0000;
      wdata_r     <= 16'h0000;
      CMD_READY   <= 1'b0;
      DONE        <= 1'b0;
      CHECK_FAIL  <= 1'b0;
      TIMEOUT     <= 1'b0;
      RANGE_SKIP  <= 1'b0;
      BYPASS_ON   <= 1'b0;
      ACCEL_HV_REQ <= 1'b0;
    end else begin
      go_r <= 1'b0;
      DONE <= 1'b0;
      case (state_r)
        S_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            CMD_READY  <= 1'b0;
            kind_r     <= CMD_KIND;
            die_r      <= CMD_DIE;
            crc_r      <= CMD_CRC;
            start_r    <= CMD_START;
            stop_r     <= CMD_STOP;
            step_r     <= 5'h00;
            CHECK_FAIL <= 1'b0;
            TIMEOUT    <= 1'b0;
            RANGE_SKIP <= (CMD_KIND == `NCB_CMD_CRC_RANGE) &&
                          (CMD_STOP <= CMD_START);
            state_r    <= S_WR;
          end
        end
        S_WR: begin
          go_r    <= 1'b1;
          rd_r    <= 1'b0;
          addr_r  <= step_addr;
          wdata_r <= step_data;
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (step_r + 5'h01 < nsteps) begin
              step_r  <= step_r + 5'h01;
              state_r <= S_WR;
            end else if (kind_r[1]) begin
              byp_r[die_r] <= (kind_r == `NCB_CMD_BYP_ENTER);
              BYPASS_ON <= (kind_r == `NCB_CMD_BYP_ENTER);
              state_r   <= S_END;
            end else begin
              poll_cnt_r  <= 16'h0000;
              have_last_r <= 1'b0;
              state_r     <= S_POLL;
            end
          end
        end
        S_POLL: begin
          go_r    <= 1'b1;
          rd_r    <= 1'b1;
          addr_r  <= `NCB_ADDR_ZERO;
          state_r <= S_PWT;
        end
        S_PWT: begin
          if (cyc_done) begin
            last_r      <= cyc_rdata;
            have_last_r <= 1'b1;
            poll_cnt_r  <= poll_cnt_r + 16'h0001;
            // two reads with a steady toggle bit mean the scan ended
            if (have_last_r && (cyc_rdata[`NCB_BIT_TOGGLE] ==
                last_r[`NCB_BIT_TOGGLE])) begin
              CHECK_FAIL <= cyc_rdata[`NCB_BIT_CHKERR];
              state_r    <= cyc_rdata[`NCB_BIT_CHKERR] ? S_CLR : S_END;
            end else if (poll_cnt_r == MAX_POLL) begin
              TIMEOUT <= 1'b1;
              state_r <= S_CLR;
            end else begin
              state_r <= S_POLL;
            end
          end
        end
        S_CLR: begin
          // error status sticks until read reset; bypass survives it
          go_r    <= 1'b1;
          rd_r    <= 1'b0;
          addr_r  <= `NCB_ADDR_ZERO;
          wdata_r <= `NCB_D_READ_RESET;
          state_r <= S_CWT;
        end
        S_CWT: begin
          if (cyc_done)
            state_r <= S_END;
        end
        default: begin
          DONE    <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // pin registers
  // --------------------------------------------------------------------
  // only the addressed die sees its chip select
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      A_OUT  <= 27'h000_0000;
      DQ_OUT <= 16'h0000;
      DQ_OE  <= 1'b0;
      CE_B   <= 2'h3;
      OE_B   <= 1'b1;
      WE_B   <= 1'b1;
    end else begin
      A_OUT  <= cyc_a;
      DQ_OUT <= cyc_dq;
      DQ_OE  <= cyc_oe;
      CE_B   <= die_r ? {cyc_ce_b, 1'b1} : {1'b1, cyc_ce_b};
      OE_B   <= cyc_oe_b;
      WE_B   <= cyc_we_b;
    end
  end

  ncb_bus_cycle u_cycle (
    .clk    (REF_CLK),
    .rst_b  (RST_B),
    .go     (go_r),
    .is_rd  (rd_r),
    .addr   (addr_r),
    .wdata  (wdata_r),
    .busy   (cyc_busy),
    .done   (cyc_done),
    .rdata  (cyc_rdata),
    .a_out  (cyc_a),
    .dq_out (cyc_dq),
    .dq_oe  (cyc_oe),
    .dq_in  (DQ_IN),
    .ce_b   (cyc_ce_b),
    .oe_b   (cyc_oe_b),
    .we_b   (cyc_we_b)
  );

endmodule // ncb_host

// ===== tb/ncb_flash_model.sv
// behavioural model of one flash die: command decode and status polling
// assumes ref_crc stands for the die's ecma crc-64, lsb first, zero seed
`timescale 1ns/1ps
module ncb_flash_model (
  // pins of one die
  input  wire         ce_b,
  input  wire         oe_b,
  input  wire         we_b,
  input  wire  [26:0] a,
  input  wire  [15:0] dq_w,
  output logic [15:0] dq_r,
  // behaviour set by the bench
  input  wire  [63:0] ref_crc,
  input  wire  [7:0]  busy_reads
);
  logic [26:0] la, wa [0:31];
  logic [15:0] ld, last, wd [0:31], w [0:9];
  logic [3:0]  st, k, cnt;
  logic        rng, err, byp, tog, hit;
  int          n_wr, busy;
  initial begin st = 0; err = 0; byp = 0; tog = 0; busy = 0; n_wr = 0; last = 0; hit = 0; end
  // latch while the strobe is low; chip select rises with the strobe, so the
  // rising strobe alone would race it
  always @* if (!we_b && !ce_b) begin la = a; ld = dq_w; hit = 1'b1; end
  task automatic launch();
    logic [30:0] s, e;
    s = {w[5], w[4][15:1]};
    e = {w[8], w[7][15:1]};
    if (rng && e <= s) return;
    busy = busy_reads;
    err = {w[3], w[2], w[1], w[0]} != ref_crc;
  endtask
  // ---------------------------------------------
  // command decode, any break drops to idle
  // ---------------------------------------------
  always @(posedge we_b) if (hit) begin
    hit = 1'b0;
    if (n_wr < 32) begin wa[n_wr] = la; wd[n_wr] = ld; n_wr++; end
    case (st)
      0: if (la == 27'h000_0555 && ld == 16'h00AA) st = 1;
         else if (la == 0 && ld == 16'h00F0) err = 0;
         else if (byp && la == 0 && ld == 16'h0090) st = 9;
      1: st = (la == 27'h000_02AA && ld == 16'h0055) ? 2 : 0;
      2: if (la == 27'h000_0555 && ld == 16'h0020) begin byp = 1; st = 0; end
         else st = (la == 0 && ld == 16'h00EB) ? 3 : 0;
      3: st = (la == 0 && ld == 16'h0027) ? 4 : 0;
      4: begin rng = ld == 16'h000A; st = (la == 0 && (rng || ld == 16'h0004)) ? 5 : 0; end
      5: begin k = 0; cnt = rng ? 10 : 4; st = (la == 0 && ld == (rng ? 16'hFFFE : 16'hFFFF)) ? 6 : 0; end
      6: if (la == k + 1) begin w[k] = ld; k++; if (k == cnt) st = 7; end else st = 0;
      7: begin st = 0; if (la == 0 && ld == 16'h0029) launch(); end
      9: begin st = 0; if (la == 0 && ld == 16'h0000) byp = 0; end
      default: st = 0;
    endcase
  end
  // status while scanning or failed, array data otherwise; released bus flips
  // chip select falls with the output strobe; look a moment later
  always @(negedge oe_b) begin #1; if (!ce_b && busy > 0) begin tog = ~tog; busy--; end end
  always @(posedge oe_b) last = dq_r;
  always @* dq_r = (oe_b || ce_b) ? ~last : (busy > 0 || err) ? {9'h0, tog, err, 5'h0} : 16'h0F0F;
endmodule // ncb_flash_model

// ===== tb/ncb_host_monitor.sv
// checker for the flash host controller pins and command port
// assumes it is bound to ncb_host with all ports by name
`timescale 1ns/1ps
module ncb_host_monitor (
  // clock and reset
  input wire        REF_CLK,
  input wire        RST_B,
  // command port
  input wire        CMD_VALID,
  input wire [1:0]  CMD_KIND,
  input wire        CMD_READY,
  input wire        DONE,
  input wire        BYPASS_ON,
  // flash pins
  input wire [26:0] A_OUT,
  input wire [15:0] DQ_OUT,
  input wire        DQ_OE,
  input wire [1:0]  CE_B,
  input wire        OE_B,
  input wire        WE_B,
  input wire        ACCEL_HV_REQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // ---------------------------------------------
  // strobe shape, pin and command port checks
  // ---------------------------------------------
  sequence wr_hold; (!WE_B && DQ_OE && $stable(DQ_OUT) && $stable(A_OUT))[*2]; endsequence
  sequence wr_end; WE_B && DQ_OE && $stable(DQ_OUT); endsequence
  sequence take(k); CMD_VALID && CMD_READY && CMD_KIND == k; endsequence
  write_hold_a: assert property ($fell(WE_B) |=> wr_hold ##1 wr_end)
    else $error("write strobe shape wrong");
  read_len_a: assert property ($fell(OE_B) |=> (!OE_B && !DQ_OE)[*3] ##1 OE_B)
    else $error("read strobe shape wrong");
  poll_addr_a: assert property (!OE_B |-> A_OUT == 27'h000_0000)
    else $error("poll read not at address zero");
  one_die_a: assert property (CE_B != 2'b00)
    else $error("both dies selected");
  strobe_excl_a: assert property (!WE_B |-> OE_B)
    else $error("read and write strobes together");
  accel_low_a: assert property (ACCEL_HV_REQ == 1'b0)
    else $error("high voltage requested");
  done_pulse_a: assert property (DONE |=> !DONE)
    else $error("done wider than one cycle");
  take_busy_a: assert property (take(CMD_KIND) |=> !CMD_READY)
    else $error("ready stayed high after accept");
  byp_enter_a: assert property (take(2'h2) |-> ##[1:200] DONE ##1 BYPASS_ON)
    else $error("bypass entry not reported");
  byp_exit_a: assert property (take(2'h3) |-> ##[1:200] DONE ##1 !BYPASS_ON)
    else $error("bypass exit not reported");
endmodule // ncb_host_monitor

// ===== tb/ncb_host_tb.sv
// self-checking bench for the flash crc and bypass host controller
// assumes two die models share the data bus, one per chip select
`timescale 1ns/1ps
module ncb_host_tb;
  typedef logic [42:0] ncb_wq_t [$];
  logic        clk, rst_b, valid, die;
  logic [1:0]  kind;
  logic [63:0] crc, ref0, ref1;
  logic [30:0] start, stop;
  logic [7:0]  br;
  wire         ready, done, fail, tmo, skip, byp, dq_oe, oe_b, we_b;
  wire  [26:0] a;
  wire  [15:0] dq_out, dq_in, d0, d1;
  wire  [1:0]  ce_b;
  int          n_mismatch, checked;
  // the host wins the bus while it drives, else the selected die
  assign dq_in = dq_oe ? dq_out : (!ce_b[0] ? d0 : d1);
  ncb_host #(.MAX_POLL(8)) ncb_host_i (.REF_CLK(clk), .RST_B(rst_b), .CMD_VALID(valid),
    .CMD_KIND(kind), .CMD_DIE(die), .CMD_CRC(crc), .CMD_START(start), .CMD_STOP(stop),
    .CMD_READY(ready), .DONE(done), .CHECK_FAIL(fail), .TIMEOUT(tmo), .RANGE_SKIP(skip),
    .BYPASS_ON(byp), .A_OUT(a), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .DQ_IN(dq_in),
    .CE_B(ce_b), .OE_B(oe_b), .WE_B(we_b), .ACCEL_HV_REQ());
  ncb_flash_model flash0_i (.ce_b(ce_b[0]), .oe_b(oe_b), .we_b(we_b), .a(a), .dq_w(dq_out),
    .dq_r(d0), .ref_crc(ref0), .busy_reads(br));
  ncb_flash_model flash1_i (.ce_b(ce_b[1]), .oe_b(oe_b), .we_b(we_b), .a(a), .dq_w(dq_out),
    .dq_r(d1), .ref_crc(ref1), .busy_reads(br));
  always #25 clk = ~clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare the writes one die saw against the expected list
  task automatic chk_seq(bit d, ncb_wq_t q);
    chk("write count", q.size(), d ? flash1_i.n_wr : flash0_i.n_wr);
    foreach (q[i]) chk($sformatf("write %0d", i), q[i], d ? {flash1_i.wa[i], flash1_i.wd[i]}
                       : {flash0_i.wa[i], flash0_i.wd[i]});
  endtask
  function automatic ncb_wq_t head(logic [15:0] cnt, logic [15:0] opt, logic [63:0] c);
    return '{{27'h000_0555, 16'h00AA}, {27'h000_02AA, 16'h0055}, {27'h000_0000, 16'h00EB},
             {27'h000_0000, 16'h0027}, {27'h000_0000, cnt}, {27'h000_0000, opt},
             {27'h000_0001, c[15:0]}, {27'h000_0002, c[31:16]}, {27'h000_0003, c[47:32]},
             {27'h000_0004, c[63:48]}};
  endfunction
  // one command through the port, bounded waits on ready and done
  task automatic run(logic [1:0] k, logic d, logic [63:0] c, logic [30:0] s, logic [30:0] e);
    int n;
    flash0_i.n_wr = 0;
    flash1_i.n_wr = 0;
    kind = k; die = d; crc = c; start = s; stop = e;
    for (n = 0; n < 100 && ready !== 1'b1; n++) @(negedge clk);
    if (n == 100) begin chk("ready", 1, 0); summarize(); end
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    for (n = 0; n < 5000 && done !== 1'b1; n++) @(negedge clk);
    if (n == 5000) begin chk("done", 1, 0); summarize(); end
    repeat (2) @(negedge clk);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic s_die_pass();
    ncb_wq_t q;
    ref0 = 64'h0123_4567_89AB_CDEF;
    run(2'h0, 1'b0, ref0, 31'h0, 31'h0);
    q = head(16'h0004, 16'hFFFF, ref0);
    q.push_back({27'h000_0000, 16'h0029});
    chk_seq(1'b0, q);
    chk("other die writes", 0, flash1_i.n_wr);
    chk("pass flag", 0, fail);
  endtask
  task automatic s_range(logic [30:0] s, logic [30:0] e);
    ncb_wq_t q;
    ref1 = 64'hFEDC_BA98_7654_3210;
    run(2'h1, 1'b1, ref1, s, e);
    q = head(16'h000A, 16'hFFFE, ref1);
    q.push_back({27'h000_0005, s[14:0], 1'b0});
    q.push_back({27'h000_0006, s[30:15]});
    q.push_back({27'h000_0007, 16'h0000});
    q.push_back({27'h000_0008, e[14:0], 1'b0});
    q.push_back({27'h000_0009, e[30:15]});
    q.push_back({27'h000_000A, 16'h0000});
    q.push_back({27'h000_0000, 16'h0029});
    chk_seq(1'b1, q);
    chk("skip flag", e <= s, skip);
    chk("range fail flag", 0, fail);
  endtask
  task automatic s_die_fail();
    run(2'h0, 1'b0, 64'h0000_0000_0000_0001, 31'h0, 31'h0);
    chk("fail flag", 1, fail);
    chk("last write", {27'h000_0000, 16'h00F0},
        {flash0_i.wa[flash0_i.n_wr - 1], flash0_i.wd[flash0_i.n_wr - 1]});
    chk("die error cleared", 0, flash0_i.err);
  endtask
  task automatic s_bypass();
    run(2'h2, 1'b1, 64'h0, 31'h0, 31'h0);
    chk_seq(1'b1, '{{27'h000_0555, 16'h00AA}, {27'h000_02AA, 16'h0055},
                    {27'h000_0555, 16'h0020}});
    chk("bypass flag on", 1, byp);
    chk("die1 bypass", 1, flash1_i.byp);
    chk("die0 bypass", 0, flash0_i.byp);
    run(2'h3, 1'b1, 64'h0, 31'h0, 31'h0);
    chk_seq(1'b1, '{{27'h000_0000, 16'h0090}, {27'h000_0000, 16'h0000}});
    chk("bypass flag off", 0, byp);
    chk("die1 bypass left", 0, flash1_i.byp);
  endtask
  task automatic s_timeout();
    br = 8'h14;
    run(2'h0, 1'b0, ref0, 31'h0, 31'h0);
    chk("timeout flag", 1, tmo);
  endtask
  initial begin
    clk = 0; rst_b = 0; valid = 0; die = 0; kind = 0; crc = 0;
    ref0 = 0; ref1 = 0; start = 0; stop = 0; br = 8'h03;
    n_mismatch = 0; checked = 0;
    repeat (10) @(negedge clk);
    rst_b = 1;
    repeat (2) @(negedge clk);
    s_die_pass();
    s_range(31'h0001_2346, 31'h0003_4568);
    s_range(31'h0000_8000, 31'h0000_8000);
    s_die_fail();
    s_bypass();
    s_timeout();
    summarize();
  end
endmodule // ncb_host_tb
bind ncb_host ncb_host_monitor ncb_host_monitor_i (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .CMD_VALID(CMD_VALID), .CMD_KIND(CMD_KIND), .CMD_READY(CMD_READY), .DONE(DONE),
  .BYPASS_ON(BYPASS_ON), .A_OUT(A_OUT), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .CE_B(CE_B),
  .OE_B(OE_B), .WE_B(WE_B), .ACCEL_HV_REQ(ACCEL_HV_REQ));
